// [design/rst_pwr_map.vh]
`ifndef RST_PWR_MAP_VH
`define RST_PWR_MAP_VH
// Power control register layout
`define PCR_IDLE_BIT        0
`define PCR_PDOWN_BIT       1
`define PCR_RESET_VAL       2'h0
// Reset qualification: two machine cycles in oscillator periods
`define RST_HOLD_OSC        24
// Internal clock runs at half the oscillator rate
`define RST_HOLD_ICLK       (`RST_HOLD_OSC / 2)
// Strobe pattern: one address latch pulse per six oscillator periods
`define ALE_PERIOD_OSC      6
`define ALE_PERIOD_ICLK     (`ALE_PERIOD_OSC / 2)
// Watchdog reset pulse length on the reset pin, in internal clocks
`define WDT_PULSE_ICLK      12
// Modes
`define MODE_RUN            2'h0
`define MODE_IDLE           2'h1
`define MODE_PDOWN          2'h2
`endif

// [design/osc_div2.v]
`timescale 1ns/100ps
`default_nettype none
// Divide-by-two stage making a one-cycle internal phase enable pulse every second rising oscillator edge
module osc_div2 (
	// Clock and reset
	input  wire clk,
	input  wire srst,
	// Oscillator level, already synchronised
	input  wire osc_level,
	input  wire osc_run,
	// Half-rate enable pulse
	output reg  half_tick
);
	reg osc_prev;
	reg phase;

	// Toggle on each rising oscillator edge while osc_run is high; only rising edges count
	always @(posedge clk) begin
		if (srst) begin
			osc_prev  <= 1'b0;
			phase     <= 1'b0;
			half_tick <= 1'b0;
		end else begin
			osc_prev  <= osc_level;
			half_tick <= 1'b0;
			if (osc_run && osc_level && !osc_prev) begin
				phase     <= ~phase; // see RULE_01
				half_tick <= phase;
			end
		end
	end
endmodule
`default_nettype wire

// [design/reset_and_low_power_control.v]
// Notes on behaviour
// RULE_01: Oscillator input passes a divide-by-two stage before timing.
// RULE_02: Reset input held high 24 oscillator periods gives a full reset.
// RULE_03: At power-on, reset stays high through start-up plus two cycles.
// RULE_04: Idle halts the processor; peripherals run; state is retained.
// RULE_05: Idle starts right after the requesting instruction completes.
// RULE_06: Any enabled interrupt ends idle, resuming at its service routine.
// RULE_07: Hardware reset ends idle and restarts as after power-on.
// RULE_08: Power-down stops the oscillator after the request; only RAM kept.
// RULE_09: Only hardware reset ends power-down; interrupts do not.
// RULE_10: Idle and power-down request bits live in the power control reg.
// RULE_11: Idle drives strobes and pulse outputs to 1; port 0 floats external.
// RULE_12: Power-down drives strobes to 0, pulse outputs 1; port 0 floats. Code floats port 0 only with ext_prog_mem; else port0_oe follows p0_oe_run.
// RULE_13: Reset pin is also driven as output on watchdog overflow.
// RULE_14: Address strobe every six periods, one skipped per data access.
// RULE_15: Idle bit clears on interrupt exit; both bits clear on reset.
// RULE_16: Reset input synchronised, applied only after full continuous hold.
`timescale 1ns/100ps
`default_nettype none
`include "rst_pwr_map.vh"
module reset_and_low_power_control #(
	parameter HOLD_ICLK  = `RST_HOLD_ICLK,
	parameter PULSE_ICLK = `WDT_PULSE_ICLK
) (
	// Clock and reset
	input  wire       clk,
	input  wire       srst,
	// Oscillator pins
	input  wire       osc_in_pin,
	output reg        osc_out_pin,
	// Reset pin, two-way
	input  wire       rst_pin_in,
	output reg        rst_pin_out,
	output reg        rst_pin_oe,
	// Core side
	input  wire       pcr_write,
	input  wire [1:0] pcr_wdata,
	input  wire       instr_done,
	input  wire       irq_enabled,
	input  wire       wdt_overflow,
	input  wire       ext_data_access,
	input  wire       ext_prog_mem,
	input  wire       ale_run,
	input  wire       fetch_strobe_run,
	input  wire [1:0] pwm_run,
	input  wire       p0_oe_run,
	input  wire       p2_addr_run,
	// Status and control toward the core
	output reg  [1:0] power_control_reg,
	output reg        core_reset,
	output reg        cpu_halt,
	output reg        periph_halt,
	output reg        irq_vector_go,
	output reg  [1:0] mode,
	output reg        iclk_tick,
	// Pin shaping
	output reg        addr_latch_strobe,
	output reg        prog_fetch_strobe,
	output reg        pulse_width_out_a,
	output reg        pulse_width_out_b,
	output reg        port0_oe,
	output reg        port2_addr_sel
);
	// Synchronisers for pin inputs
	reg        osc_s1, osc_s2;
	reg        rst_s1, rst_s2;
	reg [7:0]  hold_cnt;
	reg [7:0]  pulse_cnt;
	reg [1:0]  ale_cnt;
	reg        skip_pend;
	reg        idle_req, pd_req;
	wire       half_tick;
	wire       osc_run = (mode != `MODE_PDOWN);
	wire       qual_reset = (hold_cnt == HOLD_ICLK[7:0]);

	// ========================================
	// Pin synchronisers
	always @(posedge clk) begin
		if (srst) begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			osc_s1 <= osc_in_pin;
			osc_s2 <= osc_s1;
			rst_s1 <= rst_pin_in;
			rst_s2 <= rst_s1;
		end
	end

	osc_div2 u_div (
		.clk       (clk),
		.srst      (srst),
		.osc_level (osc_s2),
		.osc_run   (osc_run),
		.half_tick (half_tick)
	);

	// ========================================
	// Reset qualification and watchdog pulse
	always @(posedge clk) begin
		if (srst) begin
			hold_cnt    <= 8'h00;
			pulse_cnt   <= 8'h00;
			rst_pin_out <= 1'b0;
			rst_pin_oe  <= 1'b0;
			core_reset  <= 1'b1;
		end else begin
			// Count only while high; any low restarts the hold
			if (!rst_s2)
				hold_cnt <= 8'h00; // see RULE_16
			else if (!qual_reset && (half_tick || !osc_run))
				hold_cnt <= hold_cnt + 8'h01; // see RULE_02
			core_reset <= qual_reset; // see RULE_03
			// Drive the pin high for a fixed pulse on overflow
			if (wdt_overflow && mode != `MODE_PDOWN) begin
				pulse_cnt   <= PULSE_ICLK[7:0]; // see RULE_13
				rst_pin_out <= 1'b1;
				rst_pin_oe  <= 1'b1;
			end else if (pulse_cnt != 8'h00) begin
				if (half_tick)
					pulse_cnt <= pulse_cnt - 8'h01;
			end else begin
				rst_pin_out <= 1'b0;
				rst_pin_oe  <= 1'b0;
			end
		end
	end

	// ========================================
	// Mode control
	always @(posedge clk) begin
		if (srst || qual_reset) begin
			idle_req      <= 1'b0; // see RULE_15
			pd_req        <= 1'b0;
			mode          <= `MODE_RUN; // see RULE_07
			irq_vector_go <= 1'b0;
		end else begin
			irq_vector_go <= 1'b0;
			if (pcr_write && mode == `MODE_RUN) begin
				idle_req <= pcr_wdata[`PCR_IDLE_BIT]; // see RULE_10
				pd_req   <= pcr_wdata[`PCR_PDOWN_BIT];
			end
			case (mode)
				`MODE_RUN: begin
					if (instr_done && pd_req)
						mode <= `MODE_PDOWN; // see RULE_08
					else if (instr_done && idle_req)
						mode <= `MODE_IDLE; // see RULE_05
				end
				`MODE_IDLE: begin
					if (irq_enabled) begin
						mode          <= `MODE_RUN; // see RULE_06
						idle_req      <= 1'b0; // see RULE_15
						irq_vector_go <= 1'b1;
					end
				end
				`MODE_PDOWN: begin
					mode <= `MODE_PDOWN; // see RULE_09
				end
				default: mode <= `MODE_RUN;
			endcase
		end
	end

	// ========================================
	// Address strobe cadence with skip on data access
	always @(posedge clk) begin
		if (srst) begin
			ale_cnt   <= 2'h0;
			skip_pend <= 1'b0;
			iclk_tick <= 1'b0;
		end else begin
			iclk_tick <= half_tick;
			if (ext_data_access)
				skip_pend <= 1'b1;
			if (half_tick) begin
				if (ale_cnt == `ALE_PERIOD_ICLK - 1) begin
					ale_cnt <= 2'h0;
					if (skip_pend && !ext_data_access)
						skip_pend <= 1'b0;
				end else begin
					ale_cnt <= ale_cnt + 2'h1;
				end
			end
		end
	end

	// ========================================
	// Pin state per mode and oscillator output
	always @(posedge clk) begin
		if (srst) begin
			addr_latch_strobe <= 1'b0;
			prog_fetch_strobe <= 1'b1;
			pulse_width_out_a <= 1'b1;
			pulse_width_out_b <= 1'b1;
			port0_oe          <= 1'b0;
			port2_addr_sel    <= 1'b0;
			cpu_halt          <= 1'b0;
			periph_halt       <= 1'b0;
			power_control_reg <= `PCR_RESET_VAL;
			osc_out_pin       <= 1'b1;
		end else begin
			power_control_reg <= {pd_req, idle_req};
			osc_out_pin       <= osc_run ? ~osc_s2 : 1'b1; // see RULE_08
			cpu_halt          <= (mode != `MODE_RUN); // see RULE_04
			periph_halt       <= (mode == `MODE_PDOWN);
			case (mode)
				`MODE_IDLE: begin
					addr_latch_strobe <= 1'b1; // see RULE_11
					prog_fetch_strobe <= 1'b1;
					pulse_width_out_a <= 1'b1;
					pulse_width_out_b <= 1'b1;
					port0_oe          <= ext_prog_mem ? 1'b0 : p0_oe_run;
					port2_addr_sel    <= ext_prog_mem;
				end
				`MODE_PDOWN: begin
					addr_latch_strobe <= 1'b0; // see RULE_12
					prog_fetch_strobe <= 1'b0;
					pulse_width_out_a <= 1'b1;
					pulse_width_out_b <= 1'b1;
					port0_oe          <= ext_prog_mem ? 1'b0 : p0_oe_run;
					port2_addr_sel    <= 1'b0;
				end
				default: begin
					addr_latch_strobe <= ale_run && (ale_cnt == 2'h0)
						&& !skip_pend; // see RULE_14
					prog_fetch_strobe <= fetch_strobe_run;
					pulse_width_out_a <= pwm_run[0];
					pulse_width_out_b <= pwm_run[1];
					port0_oe          <= p0_oe_run;
					port2_addr_sel    <= p2_addr_run;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// [sim/rlpc_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module rlpc_properties #(
	parameter HOLD_ICLK = 12
) (
	// Clock, reset and inputs
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       rst_pin_in,
	input wire logic       instr_done,
	input wire logic       irq_enabled,
	// Outputs
	input wire logic [1:0] power_control_reg,
	input wire logic [1:0] mode,
	input wire logic       core_reset,
	input wire logic       irq_vector_go,
	input wire logic       cpu_halt,
	input wire logic       addr_latch_strobe,
	input wire logic       prog_fetch_strobe,
	input wire logic       pulse_width_out_a,
	input wire logic       osc_out_pin
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	// ========
	// Mode entry and exit
	property p_idle_in;
		mode == 2'h0 && power_control_reg == 2'h1 && instr_done
			&& !core_reset |=> mode == 2'h1;
	endproperty
	a_idle_in: assert property (p_idle_in)
		else $error("idle entry");
	property p_pd_in;
		mode == 2'h0 && power_control_reg[1] && instr_done && !core_reset
			|=> mode == 2'h2;
	endproperty
	a_pd_in: assert property (p_pd_in)
		else $error("power-down entry");
	property p_wake;
		mode == 2'h1 && irq_enabled && !core_reset
			|=> mode == 2'h0 && irq_vector_go ##[0:1] !power_control_reg[0];
	endproperty
	a_wake: assert property (p_wake)
		else $error("idle wake");
	property p_pd_stay;
		(!rst_pin_in)[*5] ##0 mode == 2'h2 |=> mode == 2'h2;
	endproperty
	a_pd_stay: assert property (p_pd_stay)
		else $error("power-down left");
	property p_idle_pins;
		mode == 2'h1 && $past(mode) == 2'h1 |-> cpu_halt
			&& addr_latch_strobe && prog_fetch_strobe && pulse_width_out_a;
	endproperty
	a_idle_pins: assert property (p_idle_pins)
		else $error("idle pins");
	property p_pd_pins;
		mode == 2'h2 && $past(mode) == 2'h2 |-> !addr_latch_strobe
			&& !prog_fetch_strobe && pulse_width_out_a && osc_out_pin;
	endproperty
	a_pd_pins: assert property (p_pd_pins)
		else $error("power-down pins");
	property p_hold;
		$rose(core_reset)
			|-> $past(rst_pin_in, 3) && $past(rst_pin_in, HOLD_ICLK);
	endproperty
	a_hold: assert property (p_hold)
		else $error("reset hold short");
	property p_clear;
		$rose(core_reset)
			|-> ##[0:2] mode == 2'h0 && power_control_reg == 2'h0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("reset clear");
	c_wake: cover property (irq_vector_go);
	c_pd: cover property (mode == 2'h2);
	c_rst: cover property ($rose(core_reset));
endmodule
bind reset_and_low_power_control rlpc_properties #(.HOLD_ICLK(HOLD_ICLK))
	chk_u (.clk(clk), .srst(srst), .rst_pin_in(rst_pin_in),
	.instr_done(instr_done), .irq_enabled(irq_enabled),
	.power_control_reg(power_control_reg), .mode(mode),
	.core_reset(core_reset), .irq_vector_go(irq_vector_go),
	.cpu_halt(cpu_halt), .addr_latch_strobe(addr_latch_strobe),
	.prog_fetch_strobe(prog_fetch_strobe),
	.pulse_width_out_a(pulse_width_out_a), .osc_out_pin(osc_out_pin));
`default_nettype wire

// [sim/osc_rst_src.sv]
`timescale 1ns/100ps
`default_nettype none
module osc_rst_src (
	// Control
	input  wire logic       run,
	input  wire logic       fire,
	input  wire logic [7:0] hold,
	// Pins
	output var  logic       osc,
	output var  logic       rst
);
	// ========
	// Oscillator, 400 ns period, frozen while stopped
	initial begin
		osc = 1'b0;
		#37;
		forever #200 if (run) osc = !osc;
	end
	// Power-on hold, then a hold of so many periods on each fire
	initial begin
		rst = 1'b1;
		#20000 rst = 1'b0;
		forever begin
			@(posedge fire);
			rst = 1'b1;
			#(hold * 400) rst = 1'b0;
		end
	end
endmodule
`default_nettype wire

// [sim/reset_and_low_power_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module reset_and_low_power_control_bench;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       fire = 1'b0;
	logic [7:0] hold = 8'h00;
	logic       pcr_write = 1'b0;
	logic [1:0] pcr_wdata = 2'h0;
	logic       instr_done = 1'b0;
	logic       irq_enabled = 1'b0;
	logic [7:0] pins = 8'h42;
	logic       osc, rst_ext, rst_out, rst_oe, seen;
	logic [1:0] pcr, mode;
	logic       core_reset, halt, vec, ale, fetch, pwa, pwb, oscout;
	logic       ph, tick, p0oe, p2sel;
	logic       wdt = 1'b0;
	int         miscompares = 0;
	int         checks_done = 0;
	// ========
	// Clock, pin wiring, instances
	always #50 clk = !clk;
	wire rst_wire = rst_ext | (rst_oe & rst_out);
	osc_rst_src part_u (.run(mode !== 2'h2), .fire(fire), .hold(hold),
		.osc(osc), .rst(rst_ext));
	reset_and_low_power_control dut_u (
		.clk(clk), .srst(srst), .osc_in_pin(osc), .osc_out_pin(oscout),
		.rst_pin_in(rst_wire), .rst_pin_out(rst_out), .rst_pin_oe(rst_oe),
		.pcr_write(pcr_write), .pcr_wdata(pcr_wdata),
		.instr_done(instr_done), .irq_enabled(irq_enabled),
		.wdt_overflow(wdt), .ext_data_access(pins[0]),
		.ext_prog_mem(pins[1]), .ale_run(pins[2]),
		.fetch_strobe_run(pins[3]),
		.pwm_run(pins[5:4]), .p0_oe_run(pins[6]), .p2_addr_run(pins[7]),
		.power_control_reg(pcr), .core_reset(core_reset), .cpu_halt(halt),
		.periph_halt(ph), .irq_vector_go(vec), .mode(mode),
		.iclk_tick(tick),
		.addr_latch_strobe(ale), .prog_fetch_strobe(fetch),
		.pulse_width_out_a(pwa), .pulse_width_out_b(pwb),
		.port0_oe(p0oe), .port2_addr_sel(p2sel));
	// ========
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input string n, input logic [1:0] e, g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_n(input string n, input int e, g);
		checks_done++;
		if (g != e) begin
			miscompares++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask
	// Cycles until the next rising address strobe, bounded
	task automatic wait_ale(output int n);
		n = 0;
		while (ale !== 1'b0 && n < 200) begin
			cyc(1);
			n++;
		end
		while (ale !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic tally_and_finish;
		if (miscompares == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic go_low(input logic [1:0] req);
		pcr_write = 1'b1;
		pcr_wdata = req;
		cyc(1);
		pcr_write = 1'b0;
		cyc(1);
		instr_done = 1'b1;
		cyc(1);
		instr_done = 1'b0;
		cyc(3);
	endtask
	task automatic pin_rst(input logic [7:0] n);
		hold = n;
		fire = 1'b1;
		seen = 1'b0;
		repeat (220) begin
			cyc(1);
			fire = 1'b0;
			seen |= core_reset;
		end
	endtask
	// ========
	// Scenarios
	task automatic t_idle;
		go_low(2'h1);
		chk("mode", 2'h1, mode);
		chk("strobes", 2'h3, {ale, fetch});
		chk("pwm", 2'h3, {pwa, pwb});
		chk("ports", 2'h1, {p0oe, p2sel});
		chk("halt", 2'h1, {ph, halt});
		irq_enabled = 1'b1;
		cyc(1);
		irq_enabled = 1'b0;
		chk("wake", 2'h3, {vec, mode == 2'h0});
		cyc(2);
		chk("pcr", 2'h0, pcr);
	endtask
	task automatic t_pdown;
		go_low(2'h3);
		chk("mode", 2'h2, mode);
		chk("strobes", 2'h0, {ale, fetch});
		chk("pwm", 2'h3, {pwa, pwb});
		chk("ports", 2'h0, {p0oe, p2sel});
		chk("halt", 2'h3, {ph, halt});
		chk("osc", 2'h1, {1'b0, oscout});
		irq_enabled = 1'b1;
		cyc(4);
		irq_enabled = 1'b0;
		chk("stay", 2'h2, mode);
		pin_rst(8'd40);
		chk("exit", 2'h0, mode);
		chk("pcr", 2'h0, pcr);
	endtask
	task automatic t_hold;
		go_low(2'h1);
		pin_rst(8'd18);
		chk("short", 2'h1, {seen, mode[0]});
		pin_rst(8'd30);
		chk("full", 2'h2, {seen, mode[0]});
	endtask
	// Tick rate, strobe cadence, skip, idle on internal memory
	task automatic t_ale;
		int n;
		n = 0;
		pins = 8'h04;
		repeat (80) begin
			cyc(1);
			n += tick;
		end
		chk_n("ticks", 10, n);
		wait_ale(n);
		wait_ale(n);
		chk_n("ale gap", 24, n);
		pins = 8'h05;
		cyc(24);
		pins = 8'h04;
		wait_ale(n);
		chk_n("ale skip", 48, n + 24);
		pins = 8'h40;
		go_low(2'h1);
		chk("ports", 2'h2, {p0oe, p2sel});
		irq_enabled = 1'b1;
		cyc(1);
		irq_enabled = 1'b0;
		cyc(2);
		chk("mode", 2'h0, mode);
	endtask
	// Watchdog pulse driven out on the reset pin
	task automatic t_wdt;
		wdt = 1'b1;
		cyc(1);
		wdt = 1'b0;
		chk("wdt pin", 2'h3, {rst_oe, rst_out});
		cyc(120);
		chk("wdt end", 2'h0, {rst_oe, rst_out});
	endtask
	// ========
	// Main sequence and watchdog
	initial begin
		cyc(6);
		srst = 1'b0;
		cyc(300);
		chk("reset", 2'h0, mode);
		t_idle();
		t_pdown();
		t_hold();
		t_ale();
		t_wdt();
		tally_and_finish();
	end
	initial begin
		cyc(4000);
		miscompares++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
